// [verilog/psr_pkg.sv]
// Package: constants, types and state layouts of the small-item resource parser
package psr_pkg;

  // ==========================================================
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_LDID   = 8'h08;
  localparam logic [7:0] OFS_LDNAME = 8'h0C;
  localparam logic [7:0] OFS_LDFLG  = 8'h10;
  localparam logic [7:0] OFS_IRQ    = 8'h14;
  localparam logic [7:0] OFS_DMA    = 8'h18;
  localparam logic [7:0] OFS_IORNG  = 8'h1C;
  localparam logic [7:0] OFS_IOINF  = 8'h20;
  localparam logic [7:0] OFS_CID0   = 8'h40;
  localparam int         CID_DEPTH  = 4;

  // Control bits
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ECLR_BIT  = 1;

  // ==========================================================
  // Small item codes and tag fields
  localparam int         TAG_TYPE_BIT = 7;
  localparam logic [3:0] IT_VERSION   = 4'h1;
  localparam logic [3:0] IT_LDID      = 4'h2;
  localparam logic [3:0] IT_CID       = 4'h3;
  localparam logic [3:0] IT_IRQ       = 4'h4;
  localparam logic [3:0] IT_DMA       = 4'h5;
  localparam logic [3:0] IT_DEPSTART  = 4'h6;
  localparam logic [3:0] IT_DEPEND    = 4'h7;
  localparam logic [3:0] IT_IOPORT    = 4'h8;
  localparam logic [3:0] IT_FIXIO     = 4'h9;
  localparam logic [3:0] IT_VENDOR    = 4'hE;
  localparam logic [3:0] IT_END       = 4'hF;

  // Field values
  localparam logic [1:0] PRIO_ACCEPT   = 2'h1;
  localparam logic [7:0] PRIO_RSV_MIN  = 8'h03;
  localparam logic [3:0] IRQ_INFO_DFLT = 4'h1;
  localparam int         IRQ_RSV_BIT   = 2;
  localparam logic [1:0] DMA_WIDTH_RSV = 2'h3;
  localparam logic [4:0] LETTER_MIN    = 5'h01;
  localparam logic [4:0] LETTER_MAX    = 5'h1A;
  localparam logic [7:0] ASCII_BASE    = 8'h40;
  localparam logic [7:0] ASCII_BAD     = 8'h3F;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_TAG  = 4'h2,
    PH_DATA = 4'h4,
    PH_END  = 4'h8
  } psr_phase_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } psr_avm_req_s;

  typedef struct packed {
    psr_phase_e        phase;
    logic [3:0]        code;
    logic [2:0]        len;
    logic [2:0]        cnt;
    logic              bad;
    logic [6:0][7:0]   item;
    logic              running;
    logic              end_seen;
    logic              sum_ok;
    logic              err;
    logic              item_done;
    logic              ready;
    logic              waitreq;
    logic [31:0]       rdata;
    logic [31:0]       ldid;
    logic [15:0]       ldflags;
    logic [2:0]        cid_num;
    logic [3:0][31:0]  cid;
    logic [15:0]       irq_mask;
    logic [3:0]        irq_info;
    logic              irq_rsv;
    logic [14:0]       dma;
    logic              in_group;
    logic [1:0]        prio;
    logic [15:0]       io_min;
    logic [15:0]       io_max;
    logic [7:0]        io_align;
    logic [7:0]        io_len;
    logic              io_dec16;
  } psr_state_s;

  typedef struct packed {
    logic [7:0] sum;
  } psr_sum_state_s;

endpackage

// [verilog/psr_id_decode.sv]
// Identifier splitter: three packed letters and the product code
module psr_id_decode (
  // Raw identifier
  input  wire logic [31:0] id_in,
  // Decoded parts
  output logic      [23:0] letters_out,
  output logic      [15:0] product_out
);

  // ==========================================================
  // Letter decode
  function automatic logic [7:0] to_ascii(input logic [4:0] c);
    // Codes outside A..Z show as a question mark
    if (c >= psr_pkg::LETTER_MIN && c <= psr_pkg::LETTER_MAX) begin
      to_ascii = psr_pkg::ASCII_BASE + {3'h0, c};
    end else begin
      to_ascii = psr_pkg::ASCII_BAD;
    end
  endfunction

  always_comb begin
    letters_out = {to_ascii(id_in[14:10]), to_ascii(id_in[9:5]), to_ascii(id_in[4:0])}; // see [RL2]
    product_out = id_in[31:16]; // see [RL3]
  end

endmodule // psr_id_decode

// [verilog/psr_sum.sv]
// Running byte sum over the resource data stream
module psr_sum (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // Control and data
  input  wire logic       clear_in,
  input  wire logic       add_in,
  input  wire logic [7:0] byte_in,
  // Sum so far
  output logic      [7:0] sum_out
);

  psr_pkg::psr_sum_state_s st_reg;
  psr_pkg::psr_sum_state_s st_next;

  always_comb begin
    st_next = st_reg;
    if (clear_in) begin
      st_next.sum = 8'h00;
    end else if (add_in) begin
      st_next.sum = st_reg.sum + byte_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sum_out = st_reg.sum;

endmodule // psr_sum

// [verilog/psr_parser.sv]
// Small-item resource descriptor parser with Avalon-MM register access
// Summary of operation
// [RL1] Bit7 zero: code bits 6-3, length 2-0
// [RL2] Low id bits: three 5-bit letters A..Z
// [RL3] Upper id half passed as product code
// [RL4] Logical id: length 5/6, LSB first, flags
// [RL5] Flag bit 0 marks boot-capable device
// [RL6] Flags map optional registers 31h to 3Fh
// [RL7] Compatible id: four bytes, LSB first, repeatable
// [RL8] Compatible ids reported in stored order
// [RL9] IRQ item length 2/3, 16-bit mask
// [RL10] IRQ mask bit 2 reserved, flagged
// [RL11] IRQ info types; absent means high edge
// [RL12] DMA item length 2, channel mask
// [RL13] DMA speed bits 6-5, bit 7 zero
// [RL14] DMA word, byte, bus-master bits
// [RL15] DMA width preference bits 1-0
// [RL16] Start group; no byte means acceptable
// [RL17] Priority 0/1/2; 3 and above flagged
// [RL18] End tag closes dependent group
// [RL19] I/O descriptor, 7 bytes, decode width
// [RL20] I/O min/max 16-bit, equal means fixed
// [RL21] Alignment above zero, then port count
// [RL22] End tag stops, checksum sums to zero
// [RL23] Bad code, length or bit: flag, skip; IRQ reserved bits flagged but mask and info still stored
module psr_parser (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rstn_in,
  // Register bus
  input  wire psr_pkg::psr_avm_req_s avm_req_in,
  output logic                [31:0] avm_readdata_out,
  output logic                       avm_waitrequest_out,
  // Resource byte stream
  input  wire logic            [7:0] byte_in,
  input  wire logic                  byte_valid_in,
  output logic                       byte_ready_out,
  // Status
  output logic                       item_done_out,
  output logic                       parse_error_out,
  output logic                       parse_end_out
);

  psr_pkg::psr_state_s st_reg;
  psr_pkg::psr_state_s st_next;

  logic            acc;
  logic            fin;
  logic [3:0]      fcode;
  logic [2:0]      flen;
  logic            fbad;
  logic            rsv;
  logic            err_set;
  logic            start;
  logic            eclr;
  logic [6:0][7:0] bufc;
  logic [7:0]      sum;
  logic [23:0]     ld_letters;
  logic [15:0]     ld_product;
  logic [31:0]     rd;

  // ==========================================================
  // Helpers
  function automatic logic len_ok(input logic [3:0] c, input logic [2:0] l);
    unique case (c)
      psr_pkg::IT_VERSION:  len_ok = (l == 3'd2);
      psr_pkg::IT_LDID:     len_ok = (l == 3'd5) || (l == 3'd6);
      psr_pkg::IT_CID:      len_ok = (l == 3'd4);
      psr_pkg::IT_IRQ:      len_ok = (l == 3'd2) || (l == 3'd3);
      psr_pkg::IT_DMA:      len_ok = (l == 3'd2);
      psr_pkg::IT_DEPSTART: len_ok = (l <= 3'd1);
      psr_pkg::IT_DEPEND:   len_ok = (l == 3'd0);
      psr_pkg::IT_IOPORT:   len_ok = (l == 3'd7);
      psr_pkg::IT_FIXIO:    len_ok = (l == 3'd3);
      psr_pkg::IT_VENDOR:   len_ok = (l != 3'd0);
      psr_pkg::IT_END:      len_ok = (l == 3'd1);
      default:              len_ok = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] word4(input logic [6:0][7:0] b);
    // Identifier bytes arrive least significant first
    word4 = {b[3], b[2], b[1], b[0]};
  endfunction

  psr_id_decode u_id (
    .id_in       (st_reg.ldid),
    .letters_out (ld_letters),
    .product_out (ld_product)
  );

  psr_sum u_sum (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .clear_in(start),
    .add_in  (acc),
    .byte_in (byte_in),
    .sum_out (sum)
  );

  // ==========================================================
  // Register read mux
  always_comb begin
    rd = 32'h0000_0000;
    if (avm_req_in.address[7:4] == psr_pkg::OFS_CID0[7:4]) begin
      rd = st_reg.cid[avm_req_in.address[3:2]]; // see [RL8]
    end else begin
      unique case (avm_req_in.address)
        psr_pkg::OFS_CTRL:   rd = {31'h0, st_reg.running};
        psr_pkg::OFS_STAT:   rd = {14'h0, st_reg.io_dec16, st_reg.io_min == st_reg.io_max,
                                   st_reg.irq_rsv, st_reg.in_group, st_reg.prio,
                                   1'b0, st_reg.cid_num, st_reg.code, st_reg.err,
                                   st_reg.sum_ok, st_reg.end_seen, st_reg.running};
        psr_pkg::OFS_LDID:   rd = st_reg.ldid;
        psr_pkg::OFS_LDNAME: rd = {8'h00, ld_letters};
        psr_pkg::OFS_LDFLG:  rd = {ld_product, st_reg.ldflags};
        psr_pkg::OFS_IRQ:    rd = {11'h0, st_reg.irq_rsv, st_reg.irq_info, st_reg.irq_mask};
        psr_pkg::OFS_DMA:    rd = {17'h0, st_reg.dma};
        psr_pkg::OFS_IORNG:  rd = {st_reg.io_max, st_reg.io_min};
        psr_pkg::OFS_IOINF:  rd = {13'h0, st_reg.io_align != 8'h00, st_reg.io_min == st_reg.io_max,
                                   st_reg.io_dec16, st_reg.io_len, st_reg.io_align};
        default:             rd = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Parser and bus control
  always_comb begin
    st_next      = st_reg;
    st_next.item_done = 1'b0;
    acc     = st_reg.ready && byte_valid_in;
    fin     = 1'b0;
    fcode   = st_reg.code;
    flen    = st_reg.len;
    fbad    = st_reg.bad;
    bufc    = st_reg.item;
    rsv     = 1'b0;
    err_set = 1'b0;
    start   = avm_req_in.write && !st_reg.waitreq && avm_req_in.byteenable[0]
              && (avm_req_in.address == psr_pkg::OFS_CTRL)
              && avm_req_in.writedata[psr_pkg::CTRL_START_BIT];
    eclr    = avm_req_in.write && !st_reg.waitreq && avm_req_in.byteenable[0]
              && (avm_req_in.address == psr_pkg::OFS_CTRL)
              && avm_req_in.writedata[psr_pkg::CTRL_ECLR_BIT];

    unique case (st_reg.phase)
      psr_pkg::PH_IDLE: begin
      end
      psr_pkg::PH_TAG: begin
        if (acc) begin
          if (byte_in[psr_pkg::TAG_TYPE_BIT]) begin
            // Large items are not walked, so their length cannot be skipped safely
            err_set       = 1'b1;
            st_next.phase = psr_pkg::PH_END;
          end else begin
            st_next.code = byte_in[6:3]; // see [RL1]
            st_next.len  = byte_in[2:0]; // see [RL1]
            st_next.cnt  = 3'd0;
            st_next.bad  = !len_ok(byte_in[6:3], byte_in[2:0]); // see [RL23]
            fcode        = byte_in[6:3];
            flen         = byte_in[2:0];
            fbad         = !len_ok(byte_in[6:3], byte_in[2:0]);
            if (byte_in[2:0] == 3'd0) begin
              fin = 1'b1;
            end else begin
              st_next.phase = psr_pkg::PH_DATA;
            end
          end
        end
      end
      psr_pkg::PH_DATA: begin
        if (acc) begin
          bufc[st_reg.cnt] = byte_in;
          st_next.item     = bufc;
          st_next.cnt      = st_reg.cnt + 3'd1;
          if (st_reg.cnt + 3'd1 == st_reg.len) begin
            // A bad item is consumed by its length before the next tag
            fin           = 1'b1; // see [RL23]
            st_next.phase = psr_pkg::PH_TAG;
          end
        end
      end
      psr_pkg::PH_END: begin
      end
      default: begin
        st_next.phase = psr_pkg::PH_IDLE;
      end
    endcase

    if (fin) begin
      st_next.item_done = 1'b1;
      if (fbad) begin
        err_set = 1'b1; // see [RL23]
      end else begin
        unique case (fcode)
          psr_pkg::IT_LDID: begin
            st_next.ldid         = word4(bufc); // see [RL4]
            st_next.ldflags[7:0] = bufc[4]; // see [RL5] [RL6]
            st_next.ldflags[15:8] = (flen == 3'd6) ? bufc[5] : 8'h00; // see [RL6]
          end
          psr_pkg::IT_CID: begin
            if (st_reg.cid_num < 3'(psr_pkg::CID_DEPTH)) begin
              st_next.cid[st_reg.cid_num[1:0]] = word4(bufc); // see [RL7] [RL8]
              st_next.cid_num = st_reg.cid_num + 3'd1; // see [RL8]
            end else begin
              err_set = 1'b1;
            end
          end
          psr_pkg::IT_IRQ: begin
            st_next.irq_mask = {bufc[1], bufc[0]}; // see [RL9]
            st_next.irq_rsv  = bufc[0][psr_pkg::IRQ_RSV_BIT]; // see [RL10]
            rsv = bufc[0][psr_pkg::IRQ_RSV_BIT];
            if (flen == 3'd3) begin
              st_next.irq_info = bufc[2][3:0]; // see [RL11]
              rsv = rsv || (bufc[2][7:4] != 4'h0);
            end else begin
              st_next.irq_info = psr_pkg::IRQ_INFO_DFLT; // see [RL11]
            end
          end
          psr_pkg::IT_DMA: begin
            rsv = bufc[1][7] || (bufc[1][1:0] == psr_pkg::DMA_WIDTH_RSV); // see [RL13] [RL15]
            if (!rsv) begin
              // Mask, speed, word, byte, master, width
              st_next.dma = {bufc[1][6:0], bufc[0]}; // see [RL12] [RL13] [RL14] [RL15]
            end
          end
          psr_pkg::IT_DEPSTART: begin
            st_next.in_group = 1'b1; // see [RL16]
            if (flen == 3'd0) begin
              st_next.prio = psr_pkg::PRIO_ACCEPT; // see [RL16]
            end else if (bufc[0] >= psr_pkg::PRIO_RSV_MIN) begin
              rsv = 1'b1; // see [RL17]
            end else begin
              st_next.prio = bufc[0][1:0]; // see [RL17]
            end
          end
          psr_pkg::IT_DEPEND: begin
            st_next.in_group = 1'b0; // see [RL18]
          end
          psr_pkg::IT_IOPORT: begin
            rsv = (bufc[0][7:1] != 7'h00);
            if (!rsv) begin
              st_next.io_dec16 = bufc[0][0]; // see [RL19]
              st_next.io_min   = {bufc[2], bufc[1]}; // see [RL20]
              st_next.io_max   = {bufc[4], bufc[3]}; // see [RL20]
              st_next.io_align = bufc[5]; // see [RL21]
              st_next.io_len   = bufc[6]; // see [RL21]
            end
          end
          psr_pkg::IT_END: begin
            // A zero checksum byte means the sum is not checked
            st_next.end_seen = 1'b1; // see [RL22]
            st_next.sum_ok   = (bufc[0] == 8'h00) || (sum + bufc[0] == 8'h00); // see [RL22]
            st_next.running  = 1'b0;
            st_next.phase    = psr_pkg::PH_END; // see [RL22]
          end
          default: begin
          end
        endcase
        err_set = err_set || rsv; // see [RL23]
      end
    end

    // Error set wins over a clear in the same cycle
    st_next.err = (st_reg.err && !eclr) || err_set;

    if (start) begin
      st_next         = '0;
      st_next.phase   = psr_pkg::PH_TAG;
      st_next.running = 1'b1;
      st_next.prio    = psr_pkg::PRIO_ACCEPT;
      st_next.irq_info = psr_pkg::IRQ_INFO_DFLT;
    end

    // One wait cycle per access; read data stands with the low waitrequest
    st_next.waitreq = !((avm_req_in.read || avm_req_in.write) && st_reg.waitreq);
    st_next.rdata   = (avm_req_in.read && st_reg.waitreq) ? rd : st_reg.rdata;
    st_next.ready   = st_next.running
                      && ((st_next.phase == psr_pkg::PH_TAG)
                      || (st_next.phase == psr_pkg::PH_DATA)); // see [RL22]
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_reg          <= '0;
      st_reg.phase    <= psr_pkg::PH_IDLE;
      st_reg.waitreq  <= 1'b1;
      st_reg.prio     <= psr_pkg::PRIO_ACCEPT;
      st_reg.irq_info <= psr_pkg::IRQ_INFO_DFLT;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avm_readdata_out    = st_reg.rdata;
  assign avm_waitrequest_out = st_reg.waitreq;
  assign byte_ready_out      = st_reg.ready;
  assign item_done_out       = st_reg.item_done;
  assign parse_error_out     = st_reg.err;
  assign parse_end_out       = st_reg.end_seen;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  logic fin_ok;
  assign fin_ok = fin && !fbad && !start;

  a_small_tag_fields: assert property ( // see [RL1]
    (st_reg.phase == psr_pkg::PH_TAG) && acc && !byte_in[7] && !start
    |=> (st_reg.code == $past(byte_in[6:3])) && (st_reg.len == $past(byte_in[2:0])))
    else $error("tag fields not captured");
  a_ldid_lsb_first: assert property ( // see [RL4]
    fin_ok && (fcode == psr_pkg::IT_LDID)
    |=> st_reg.ldid[7:0] == $past(bufc[0]))
    else $error("logical id byte order wrong");
  a_boot_flag_bit: assert property ( // see [RL5]
    fin_ok && (fcode == psr_pkg::IT_LDID)
    |=> st_reg.ldflags[0] == $past(bufc[4][0]))
    else $error("boot flag not taken");
  a_cid_in_order: assert property ( // see [RL8]
    fin_ok && (fcode == psr_pkg::IT_CID) && (st_reg.cid_num < 3'd4)
    |=> st_reg.cid_num == $past(st_reg.cid_num) + 3'd1)
    else $error("compatible id order lost");
  a_irq_bit2_flag: assert property ( // see [RL10]
    fin_ok && (fcode == psr_pkg::IT_IRQ) && bufc[0][2]
    |=> st_reg.irq_rsv && st_reg.err)
    else $error("reserved irq bit not flagged");
  a_irq_info_dflt: assert property ( // see [RL11]
    fin_ok && (fcode == psr_pkg::IT_IRQ) && (flen == 3'd2)
    |=> st_reg.irq_info == 4'h1)
    else $error("irq info default wrong");
  a_prio_default: assert property ( // see [RL16]
    fin_ok && (fcode == psr_pkg::IT_DEPSTART) && (flen == 3'd0)
    |=> st_reg.in_group && (st_reg.prio == 2'h1))
    else $error("default priority wrong");
  a_end_stops: assert property ( // see [RL22]
    st_reg.end_seen |-> !st_reg.ready)
    else $error("parser runs past end tag");
  a_bad_len_err: assert property ( // see [RL23]
    fin && fbad && !start |=> st_reg.err && st_reg.item_done)
    else $error("bad item not flagged");
  a_bus_one_wait: assert property (
    (avm_req_in.read || avm_req_in.write) && st_reg.waitreq |=> !st_reg.waitreq ##1 st_reg.waitreq)
    else $error("bus answer not one cycle");

endmodule // psr_parser

// [test/psr_byte_store.sv]
// Card byte store model that feeds the resource data stream
module psr_byte_store (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // Pacing
  input  wire logic       slow_in,
  // Byte stream
  input  wire logic       ready_in,
  output logic      [7:0] byte_out,
  output logic            valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Storage
  logic [7:0] mem [0:63];
  int         wr_ptr = 0;
  int         rd_ptr = 0;
  logic [7:0] last   = 8'h00;
  logic       tog    = 1'b0;

  // Loaded only while the parser refuses bytes, so no edge sees a half load
  task automatic clear();
    wr_ptr = 0;
    rd_ptr = 0;
  endtask

  task automatic put(input logic [7:0] b);
    mem[wr_ptr] = b;
    wr_ptr = wr_ptr + 1;
  endtask

  // ==========================================================
  // Stream side
  // Slow mode offers a byte every other cycle only
  assign valid_out = (rd_ptr != wr_ptr) && !(slow_in && tog);
  // Idle line shows the inverse of the last byte, never a stale copy
  assign byte_out  = valid_out ? mem[rd_ptr] : ~last;

  always @(posedge clk_in) begin
    tog <= ~tog;
    if (rstn_in && valid_out && ready_in) begin
      last   <= mem[rd_ptr];
      rd_ptr <= rd_ptr + 1;
    end
  end
endmodule // psr_byte_store

// [test/psr_parser_test.sv]
// Self-checking testbench of the small-item resource parser
module psr_parser_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic                  clk_in  = 1'b0;
  logic                  rstn_in = 1'b0;
  logic                  slow    = 1'b0;
  psr_pkg::psr_avm_req_s avm_req = '0;
  logic           [31:0] avm_readdata;
  logic                  avm_waitreq;
  logic            [7:0] byte_data;
  logic                  byte_valid;
  logic                  byte_ready;
  logic                  item_done;
  logic                  parse_error;
  logic                  parse_end;
  logic            [7:0] q [$];
  int                    miscompares = 0;
  int                    n_compared  = 0;
  int                    n_items     = 0;

  initial forever #12.5 clk_in = ~clk_in;

  psr_parser i_psr_parser (
    .clk_in(clk_in), .rstn_in(rstn_in),
    .avm_req_in(avm_req), .avm_readdata_out(avm_readdata),
    .avm_waitrequest_out(avm_waitreq),
    .byte_in(byte_data), .byte_valid_in(byte_valid), .byte_ready_out(byte_ready),
    .item_done_out(item_done), .parse_error_out(parse_error), .parse_end_out(parse_end)
  );

  psr_byte_store i_psr_byte_store (
    .clk_in(clk_in), .rstn_in(rstn_in), .slow_in(slow),
    .ready_in(byte_ready), .byte_out(byte_data), .valid_out(byte_valid)
  );

  // Pulses are counted mid-cycle, where registered outputs are settled
  always @(negedge clk_in) if (item_done === 1'b1) n_items++;

  // ==========================================================
  // Tasks
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n = 0;
    @(posedge clk_in);
    avm_req <= '{read: ~wr, write: wr, address: a, byteenable: 4'hF, writedata: wd};
    // Waitrequest and read data are taken as they stand at the sampling edge
    do begin
      @(posedge clk_in);
      n++;
    end while (avm_waitreq !== 1'b0 && n < 20);
    if (avm_waitreq !== 1'b0) begin
      miscompares++;
      end_of_test();
    end
    rd = avm_readdata;
    avm_req <= '0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    bus(1'b1, a, d, unused);
  endtask

  task automatic check_reg(input string what, input logic [7:0] a, input logic [31:0] msk,
                           input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    check(what, d & msk, exp);
  endtask

  // Loads q plus an end tag, starts parsing and waits for the end flag
  task automatic run(input logic [7:0] cs_adj);
    logic [7:0] s = 8'h79;
    int         n = 0;
    i_psr_byte_store.clear();
    foreach (q[i]) begin
      i_psr_byte_store.put(q[i]);
      s += q[i];
    end
    i_psr_byte_store.put(8'h79);
    i_psr_byte_store.put(8'h00 - s + cs_adj);
    q.delete();
    n_items = 0;
    wr_reg(psr_pkg::OFS_CTRL, 32'h0000_0001);
    // The end flag of the last run stands until the start edge has passed
    do begin
      @(negedge clk_in);
      n++;
    end while (parse_end !== 1'b1 && n < 200);
    if (parse_end !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    @(negedge clk_in);
    check("ready after end", byte_ready, 32'h0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] b2;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    // Cleared I/O limits are equal, so the fixed-location bit reads one
    check_reg("stat reset", psr_pkg::OFS_STAT, 32'h3F7FE, 32'h0001_1000);
    check_reg("irq reset", psr_pkg::OFS_IRQ, '1, 32'h0001_0000);
    wr_reg(8'h30, 32'hFFFF_FFFF);
    check_reg("unmapped", 8'h30, '1, 32'h0);
    // Card powers up active, so boot bit is set in the first flag byte
    q = {8'h16, 8'h5A, 8'h04, 8'h34, 8'h12, 8'h03, 8'h80,
         8'h1C, 8'h11, 8'h22, 8'h33,
         8'h44, 8'h1C, 8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'h22, 8'h20, 8'h80, 8'h2A, 8'h0A,
         8'h5D, 8'h30, 8'h47, 8'h01, 8'h20, 8'h03, 8'h20, 8'h03, 8'h08, 8'h04, 8'h38};
    run(8'h00);
    check("items a", n_items, 32'd9);
    check("error a", parse_error, 32'h0);
    check_reg("ldid", psr_pkg::OFS_LDID, '1, 32'h1234_045A);
    check_reg("letters", psr_pkg::OFS_LDNAME, '1, 32'h0041_425A);
    check_reg("flags", psr_pkg::OFS_LDFLG, '1, 32'h1234_8003);
    check_reg("cid0", psr_pkg::OFS_CID0, '1, 32'h4433_2211);
    check_reg("cid1", psr_pkg::OFS_CID0 + 8'h04, '1, 32'hD4C3_B2A1);
    check_reg("irq a", psr_pkg::OFS_IRQ, '1, 32'h0001_8020);
    check_reg("dma a", psr_pkg::OFS_DMA, '1, 32'h0000_5D0A);
    check_reg("io range", psr_pkg::OFS_IORNG, '1, 32'h0320_0320);
    check_reg("io info", psr_pkg::OFS_IOINF, '1, 32'h0007_0408);
    check_reg("stat a", psr_pkg::OFS_STAT, 32'h3F7FE, 32'h0003_12F6);
    // Reserved bits, a bad length, reserved code and a wrong checksum
    q = {8'h23, 8'h04, 8'h00, 8'h0C, 8'h2A, 8'hFF, 8'h03, 8'h31, 8'h02, 8'h31, 8'h05,
         8'h15, 8'h21, 8'h08, 8'h00, 8'h00, 8'h01, 8'h1B, 8'h01, 8'h02, 8'h03, 8'h51,
         8'hEE};
    run(8'h01);
    check("items b", n_items, 32'd8);
    check("error b", parse_error, 32'h1);
    check_reg("irq b", psr_pkg::OFS_IRQ, '1, 32'h001C_0004);
    check_reg("dma b", psr_pkg::OFS_DMA, '1, 32'h0);
    check_reg("letters b", psr_pkg::OFS_LDNAME, '1, 32'h0042_4141);
    check_reg("flags b", psr_pkg::OFS_LDFLG, '1, 32'h0000_0001);
    check_reg("cid b", psr_pkg::OFS_CID0, '1, 32'h0);
    check_reg("stat b", psr_pkg::OFS_STAT, 32'h3F7FE, 32'h0001_E0FA);
    wr_reg(psr_pkg::OFS_CTRL, 32'h0000_0002);
    check_reg("err clear", psr_pkg::OFS_STAT, 32'h8, 32'h0);
    // Every DMA timing code, with the partner stalling every other cycle
    slow <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      b2 = {1'b0, k[1:0], 3'b101, 2'(k % 3)};
      q = {8'h2A, 8'h01 << k, b2};
      run(8'h00);
      check_reg("dma timing", psr_pkg::OFS_DMA, '1, {17'h0, b2[6:0], 8'h01 << k});
    end
    // Range I/O with 10-bit decode and a checksum byte of zero
    q = {8'h47, 8'h00, 8'h00, 8'h01, 8'h80, 8'h03, 8'h00, 8'h08};
    run(8'h4C);
    check("items c", n_items, 32'd2);
    check_reg("io range c", psr_pkg::OFS_IORNG, '1, 32'h0380_0100);
    check_reg("io info c", psr_pkg::OFS_IOINF, '1, 32'h0000_0800);
    check_reg("stat c", psr_pkg::OFS_STAT, 32'h3000E, 32'h0000_0006);
    end_of_test();
  end
endmodule // psr_parser_test
